/* File: hdl/cxt_exec.sv */
// Execution unit for exchange, system command, test-under-mask and xor.
// Assumes a decoder presenting one instruction at a time and a data
// memory that answers a read within the cycle its strobe is high.
// Notes on behaviour
// - Exchange swaps general and special, flags kept
// - Exchange with status specials is invalid
// - Index pair is high byte over low
// - System command drives code bus, strobe low
// - System command only advances program counter
// - Test ANDs register with immediate for flags
// - Test writes nothing back
// - Zero and negative follow the 8-bit result
// - Xor stores result; four second-operand kinds
// - Four index-indirect forms, 5-bit offset
// - Suffixed forms keep index pair unchanged
`timescale 1ns/1ps
`include "cxt_consts.svh"
module cxt_exec (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              instr_valid_i,
  output logic                   instr_ready_o,
  input  wire cxt_pkg::cxt_op_t  op_i,
  input  wire cxt_pkg::cxt_src_t src_i,
  input  wire cxt_pkg::cxt_idm_t idm_i,
  input  wire cxt_pkg::cxt_spr_t spr_sel_i,
  input  wire logic [1:0]        gpr_sel_i,
  input  wire logic [1:0]        gpr_src_i,
  input  wire logic              idx_sel_i,
  input  wire logic [4:0]        offset_i,
  input  wire logic [7:0]        imm_i,
  input  wire logic              eid_i,
  output logic [15:0]            dm_addr_o,
  output logic                   dm_rd_o,
  input  wire logic [7:0]        dm_rdata_i,
  output logic [7:0]             system_code_bus_o,
  output logic                   system_command_strobe_n_o,
  output logic [19:0]            program_counter_o,
  output logic [7:0]             status_o,
  output logic [15:0]            index_pair_first_o,
  output logic [15:0]            index_pair_second_o,
  output logic [31:0]            gpr_flat_o,
  output logic                   done_o,
  output logic                   invalid_o
);
  cxt_pkg::cxt_state_t state_reg, state_next;
  logic [7:0]  gpr_reg [4];
  logic [7:0]  gpr_next [4];
  logic [7:0]  idh_reg, idh_next, index_low_byte_first_reg, index_low_byte_first_next, idl1_reg, idl1_next;
  logic [7:0]  sr0_reg, sr0_next, sr1_reg, sr1_next;
  logic [19:0] pc_reg, pc_next;
  logic [7:0]  code_reg, code_next;
  logic        stb_n_reg, stb_n_next, rd_reg, rd_next, done_reg, done_next;
  logic        inv_reg, inv_next;
  logic [15:0] addr_reg, addr_next;
  logic [1:0]  pend_reg, pend_next;
  logic [7:0]  spr_val, res;
  logic        acc, bad_spr;
  cxt_agu_if   agu_bus ();

  cxt_agu u_agu (.a(agu_bus));

  function automatic logic [7:0] set_zn(input logic [7:0] sr, input logic [7:0] r);
    logic [7:0] s;
    s = sr;
    s[`CXT_FLAG_Z] = (r == `CXT_BYTE_ZERO);
    s[`CXT_FLAG_N] = r[`CXT_MSB];
    return s;
  endfunction

  assign acc           = instr_valid_i && instr_ready_o;
  assign instr_ready_o = (state_reg == cxt_pkg::ST_IDLE);
  assign bad_spr       = (spr_sel_i == cxt_pkg::SPR_SR0) || (spr_sel_i == cxt_pkg::SPR_SR1);
  assign agu_bus.base  = idx_sel_i ? {idh_reg, idl1_reg} : {idh_reg, index_low_byte_first_reg};
  assign agu_bus.mode  = idm_i;
  assign agu_bus.offset = offset_i;

  always_comb begin
    case (spr_sel_i)
      cxt_pkg::SPR_IDH:  spr_val = idh_reg;
      cxt_pkg::SPR_INDEX_LOW_BYTE_FIRST: spr_val = index_low_byte_first_reg;
      cxt_pkg::SPR_IDL1: spr_val = idl1_reg;
      default:           spr_val = `CXT_BYTE_ZERO;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    gpr_next   = gpr_reg;
    idh_next   = idh_reg;
    index_low_byte_first_next  = index_low_byte_first_reg;
    idl1_next  = idl1_reg;
    sr0_next   = sr0_reg;
    sr1_next   = sr1_reg;
    pc_next    = pc_reg;
    code_next  = code_reg;
    addr_next  = addr_reg;
    pend_next  = pend_reg;
    stb_n_next = 1'b1;
    rd_next    = 1'b0;
    done_next  = 1'b0;
    inv_next   = 1'b0;
    res        = `CXT_BYTE_ZERO;
    case (state_reg)
      cxt_pkg::ST_IDLE: begin
        if (instr_valid_i) begin
          case (op_i)
            cxt_pkg::OP_SWAP: begin
              if (bad_spr) begin
                inv_next = 1'b1;
              end else begin
                gpr_next[gpr_sel_i] = spr_val;
                case (spr_sel_i)
                  cxt_pkg::SPR_IDH:  idh_next  = gpr_reg[gpr_sel_i];
                  cxt_pkg::SPR_INDEX_LOW_BYTE_FIRST: index_low_byte_first_next = gpr_reg[gpr_sel_i];
                  default:           idl1_next = gpr_reg[gpr_sel_i];
                endcase
                pc_next   = pc_reg + `CXT_PC_STEP;
                done_next = 1'b1;
              end
            end
            cxt_pkg::OP_SYS: begin
              code_next  = imm_i;
              stb_n_next = 1'b0;
              pc_next    = pc_reg + `CXT_PC_STEP;
              done_next  = 1'b1;
            end
            cxt_pkg::OP_TM: begin
              res       = gpr_reg[gpr_sel_i] & imm_i;
              sr0_next  = set_zn(sr0_reg, res);
              pc_next   = pc_reg + `CXT_PC_STEP;
              done_next = 1'b1;
            end
            cxt_pkg::OP_XOR: begin
              pend_next = gpr_sel_i;
              if (src_i == cxt_pkg::SRC_IMM || src_i == cxt_pkg::SRC_GPR) begin
                res = gpr_reg[gpr_sel_i] ^
                      ((src_i == cxt_pkg::SRC_IMM) ? imm_i : gpr_reg[gpr_src_i]);
                gpr_next[gpr_sel_i] = res;
                sr0_next  = set_zn(sr0_reg, res);
                pc_next   = pc_reg + `CXT_PC_STEP;
                done_next = 1'b1;
              end else if (src_i == cxt_pkg::SRC_DIR) begin
                addr_next  = {(eid_i ? idh_reg : `CXT_DIRECT_PAGE), imm_i};
                rd_next    = 1'b1;
                state_next = cxt_pkg::ST_MEM;
              end else begin
                addr_next  = agu_bus.addr;
                rd_next    = 1'b1;
                state_next = cxt_pkg::ST_MEM;
                if (agu_bus.wb_en && idx_sel_i) begin
                  idl1_next = agu_bus.low_wb;
                end else if (agu_bus.wb_en) begin
                  index_low_byte_first_next = agu_bus.low_wb;
                end
              end
            end
            default: begin
              pc_next   = pc_reg + `CXT_PC_STEP;
              done_next = 1'b1;
            end
          endcase
        end
      end
      default: begin
        res = gpr_reg[pend_reg] ^ dm_rdata_i;
        gpr_next[pend_reg] = res;
        sr0_next   = set_zn(sr0_reg, res);
        pc_next    = pc_reg + `CXT_PC_STEP;
        done_next  = 1'b1;
        state_next = cxt_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= cxt_pkg::ST_IDLE;
      for (int i = 0; i < 4; i++) begin
        gpr_reg[i] <= `CXT_BYTE_ZERO;
      end
      idh_reg   <= `CXT_IDX_RST;
      index_low_byte_first_reg  <= `CXT_IDX_RST;
      idl1_reg  <= `CXT_IDX_RST;
      sr0_reg   <= `CXT_SR_RST;
      sr1_reg   <= `CXT_SR_RST;
      pc_reg    <= `CXT_PC_RST;
      code_reg  <= `CXT_CODE_RST;
      addr_reg  <= `CXT_ADDR_RST;
      pend_reg  <= 2'h0;
      stb_n_reg <= 1'b1;
      rd_reg    <= 1'b0;
      done_reg  <= 1'b0;
      inv_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      gpr_reg   <= gpr_next;
      idh_reg   <= idh_next;
      index_low_byte_first_reg  <= index_low_byte_first_next;
      idl1_reg  <= idl1_next;
      sr0_reg   <= sr0_next;
      sr1_reg   <= sr1_next;
      pc_reg    <= pc_next;
      code_reg  <= code_next;
      addr_reg  <= addr_next;
      pend_reg  <= pend_next;
      stb_n_reg <= stb_n_next;
      rd_reg    <= rd_next;
      done_reg  <= done_next;
      inv_reg   <= inv_next;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_flat
    assign gpr_flat_o[g*8 +: 8] = gpr_reg[g];
  end

  assign dm_addr_o                 = addr_reg;
  assign dm_rd_o                   = rd_reg;
  assign system_code_bus_o         = code_reg;
  assign system_command_strobe_n_o = stb_n_reg;
  assign program_counter_o         = pc_reg;
  assign status_o                  = sr0_reg;
  assign index_pair_first_o        = {idh_reg, index_low_byte_first_reg};
  assign index_pair_second_o       = {idh_reg, idl1_reg};
  assign done_o                    = done_reg;
  assign invalid_o                 = inv_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  swap_exchange_a: assert property (acc && op_i == cxt_pkg::OP_SWAP && !bad_spr |=>
    gpr_reg[$past(gpr_sel_i)] == $past(spr_val) && sr0_reg == $past(sr0_reg))
    else $error("exchange result wrong");
  swap_reject_a: assert property (acc && op_i == cxt_pkg::OP_SWAP && bad_spr |=>
    invalid_o && pc_reg == $past(pc_reg) && gpr_flat_o == $past(gpr_flat_o))
    else $error("status special accepted by exchange");
  idx_pair_a: assert property (acc && op_i == cxt_pkg::OP_XOR && src_i == cxt_pkg::SRC_IDM
    && idm_i == cxt_pkg::IDM_ADD_KEEP && !idx_sel_i |=>
    dm_addr_o == $past({idh_reg, index_low_byte_first_reg}) + {`CXT_OFS_PAD, $past(offset_i)})
    else $error("index pair address wrong");
  sys_strobe_a: assert property (acc && op_i == cxt_pkg::OP_SYS |=>
    !system_command_strobe_n_o && system_code_bus_o == $past(imm_i) ##1
    (system_command_strobe_n_o || $past(acc && op_i == cxt_pkg::OP_SYS)))
    else $error("system command strobe wrong");
  sys_quiet_a: assert property (acc && op_i == cxt_pkg::OP_SYS |=>
    pc_reg == $past(pc_reg) + `CXT_PC_STEP && sr0_reg == $past(sr0_reg)
    && $stable(gpr_flat_o) && $stable(index_pair_first_o)) else $error("system command side effect");
  tm_flags_a: assert property (acc && op_i == cxt_pkg::OP_TM |=>
    status_o[`CXT_FLAG_Z] == (($past(gpr_reg[gpr_sel_i]) & $past(imm_i)) == `CXT_BYTE_ZERO))
    else $error("test zero flag wrong");
  tm_keep_a: assert property (acc && op_i == cxt_pkg::OP_TM |=> $stable(gpr_flat_o))
    else $error("test wrote a register");
  xor_neg_a: assert property (acc && op_i == cxt_pkg::OP_XOR && src_i == cxt_pkg::SRC_IMM |=>
    status_o[`CXT_FLAG_N] == gpr_reg[$past(gpr_sel_i)][`CXT_MSB]) else $error("negative flag wrong");
  xor_imm_a: assert property (acc && op_i == cxt_pkg::OP_XOR && src_i == cxt_pkg::SRC_IMM |=>
    gpr_reg[$past(gpr_sel_i)] == ($past(gpr_reg[gpr_sel_i]) ^ $past(imm_i)))
    else $error("xor result wrong");
  keep_index_a: assert property (acc && op_i == cxt_pkg::OP_XOR && src_i == cxt_pkg::SRC_IDM
    && (idm_i == cxt_pkg::IDM_ADD_KEEP || idm_i == cxt_pkg::IDM_SUB_KEEP) |=>
    $stable(index_pair_first_o) && $stable(index_pair_second_o)) else $error("index changed");
  post_add_a: assert property (acc && op_i == cxt_pkg::OP_XOR && src_i == cxt_pkg::SRC_IDM
    && idm_i == cxt_pkg::IDM_POST_ADD && !idx_sel_i |=> dm_addr_o == $past(index_pair_first_o)
    && index_low_byte_first_reg == $past(index_low_byte_first_reg) + {3'h0, $past(offset_i)}) else $error("post add wrong");
  direct_page_a: assert property (acc && op_i == cxt_pkg::OP_XOR && src_i == cxt_pkg::SRC_DIR
    && eid_i |=> dm_addr_o[15:8] == $past(idh_reg) ##1 done_o) else $error("direct page wrong");
  cv_keep_a: assert property (acc && (op_i == cxt_pkg::OP_TM || op_i == cxt_pkg::OP_XOR) |=>
    $stable(status_o[`CXT_FLAG_C]) && $stable(status_o[`CXT_FLAG_V]) ##1
    $stable(status_o[`CXT_FLAG_C]) && $stable(status_o[`CXT_FLAG_V])) else $error("carry changed");

  sys_stop_c: cover property (acc && op_i == cxt_pkg::OP_SYS && imm_i == 8'h0a);
  xor_mem_c: cover property (acc && op_i == cxt_pkg::OP_XOR && src_i == cxt_pkg::SRC_IDM ##2 done_o);
  swap_ok_c: cover property (acc && op_i == cxt_pkg::OP_SWAP && !bad_spr);
endmodule

/* File: hdl/cxt_consts.svh */
// Constants for the exchange/test/xor/system-command execution block.
// Assumes inclusion by bare name from design files only.
`ifndef CXT_CONSTS_SVH
`define CXT_CONSTS_SVH
`define CXT_FLAG_C      0
`define CXT_FLAG_Z      1
`define CXT_FLAG_V      2
`define CXT_FLAG_N      3
`define CXT_MSB         7
`define CXT_BYTE_ZERO   8'h00
`define CXT_SR_RST      8'h00
`define CXT_IDX_RST     8'h00
`define CXT_PC_RST      20'h00000
`define CXT_PC_STEP     20'h00001
`define CXT_CODE_RST    8'h00
`define CXT_ADDR_RST    16'h0000
`define CXT_DIRECT_PAGE 8'h00
`define CXT_OFS_PAD     11'h000
`endif

/* File: hdl/cxt_pkg.sv */
// Types shared by the execution block and its index address unit.
// Assumes nothing beyond a SystemVerilog compiler.
package cxt_pkg;
  typedef enum logic [2:0] {OP_NOP, OP_SWAP, OP_SYS, OP_TM, OP_XOR} cxt_op_t;
  typedef enum logic [1:0] {SRC_DIR, SRC_IMM, SRC_GPR, SRC_IDM} cxt_src_t;
  typedef enum logic [1:0] {IDM_POST_ADD, IDM_PRE_SUB, IDM_ADD_KEEP, IDM_SUB_KEEP} cxt_idm_t;
  typedef enum logic [2:0] {SPR_IDH, SPR_INDEX_LOW_BYTE_FIRST, SPR_IDL1, SPR_SR0, SPR_SR1} cxt_spr_t;
  typedef enum logic {ST_IDLE, ST_MEM} cxt_state_t;
endpackage

/* File: hdl/cxt_agu_if.sv */
// Carrier between the execution core and its index address unit.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface cxt_agu_if;
  logic [15:0]       base;
  cxt_pkg::cxt_idm_t mode;
  logic [4:0]        offset;
  logic [15:0]       addr;
  logic [7:0]        low_wb;
  logic              wb_en;
  modport agu  (input base, input mode, input offset, output addr, output low_wb, output wb_en);
  modport core (output base, output mode, output offset, input addr, input low_wb, input wb_en);
endinterface

/* File: hdl/cxt_agu.sv */
// Index-indirect address unit: access address and index write-back.
// Assumes base is the selected index pair, high byte on top.
`timescale 1ns/1ps
`include "cxt_consts.svh"
module cxt_agu (
  cxt_agu_if.agu a
);
  logic [15:0] plus;
  logic [15:0] minus;
  always_comb begin
    plus     = a.base + {`CXT_OFS_PAD, a.offset};
    minus    = a.base - {`CXT_OFS_PAD, a.offset};
    a.addr   = a.base;
    a.low_wb = plus[7:0];
    a.wb_en  = 1'b1;
    case (a.mode)
      cxt_pkg::IDM_POST_ADD: begin
        a.addr   = a.base;
        a.low_wb = plus[7:0];
        a.wb_en  = 1'b1;
      end
      cxt_pkg::IDM_PRE_SUB: begin
        a.addr   = minus;
        a.low_wb = minus[7:0];
        a.wb_en  = 1'b1;
      end
      cxt_pkg::IDM_ADD_KEEP: begin
        a.addr   = plus;
        a.wb_en  = 1'b0;
      end
      default: begin
        a.addr   = minus;
        a.wb_en  = 1'b0;
      end
    endcase
  end
endmodule

/* File: sim/cxt_periph.sv */
// Model of the peripheral logic that decodes system command codes.
// Assumes the code bus is valid in the cycle the strobe is low.
`timescale 1ns/1ps
module cxt_periph (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] system_code_bus_i,
  input  wire logic       system_command_strobe_n_i,
  output logic            stop_req_o,
  output logic            idle_req_o
);
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stop_req_o <= 1'b0;
      idle_req_o <= 1'b0;
    end else begin
      stop_req_o <= !system_command_strobe_n_i && system_code_bus_i == 8'h0a;
      idle_req_o <= !system_command_strobe_n_i && system_code_bus_i == 8'h05;
    end
  end
endmodule

/* File: sim/cpu_exchange_test_xor_sys_exec_tb.sv */
// Self-checking bench for the execution block with a reference model.
// Assumes the data memory answers in the cycle its read strobe is high.
`timescale 1ns/1ps
module cpu_exchange_test_xor_sys_exec_tb;
  logic                clk_sys_i = 1'b0;
  logic                sys_rst_i = 1'b1;
  logic                instr_valid_i = 1'b0;
  cxt_pkg::cxt_op_t    op_i = cxt_pkg::OP_NOP;
  cxt_pkg::cxt_src_t   src_i = cxt_pkg::SRC_DIR;
  cxt_pkg::cxt_idm_t   idm_i = cxt_pkg::IDM_POST_ADD;
  cxt_pkg::cxt_spr_t   spr_sel_i = cxt_pkg::SPR_IDH;
  logic [1:0]          gpr_sel_i = 2'h0;
  logic [1:0]          gpr_src_i = 2'h0;
  logic                idx_sel_i = 1'b0;
  logic [4:0]          offset_i = 5'h00;
  logic [7:0]          imm_i = 8'h00;
  logic                eid_i = 1'b0;
  logic                instr_ready_o, dm_rd_o, system_command_strobe_n_o, done_o, invalid_o;
  logic [15:0]         dm_addr_o, index_pair_first_o, index_pair_second_o;
  logic [7:0]          dm_rdata_i, system_code_bus_o, status_o;
  logic [19:0]         program_counter_o;
  logic [31:0]         gpr_flat_o;
  logic                stop_req, idle_req;
  logic [101:0]        expq [$];
  logic [101:0]        ex;
  logic [7:0]          gpr [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]          index_high_byte = 8'h00, il0 = 8'h00, il1 = 8'h00, st = 8'h00, cd = 8'h00;
  logic [19:0]         pc = 20'h00000;
  logic [7:0]          cyc = 8'h00;
  int                  errors = 0, compares = 0, nstop = 0, nidle = 0, gstop = 0, gidle = 0;

  initial forever #20 clk_sys_i = ~clk_sys_i;

  cxt_exec DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
    .instr_ready_o(instr_ready_o), .op_i(op_i), .src_i(src_i), .idm_i(idm_i),
    .spr_sel_i(spr_sel_i), .gpr_sel_i(gpr_sel_i), .gpr_src_i(gpr_src_i),
    .idx_sel_i(idx_sel_i), .offset_i(offset_i), .imm_i(imm_i), .eid_i(eid_i),
    .dm_addr_o(dm_addr_o), .dm_rd_o(dm_rd_o), .dm_rdata_i(dm_rdata_i),
    .system_code_bus_o(system_code_bus_o),
    .system_command_strobe_n_o(system_command_strobe_n_o),
    .program_counter_o(program_counter_o), .status_o(status_o),
    .index_pair_first_o(index_pair_first_o), .index_pair_second_o(index_pair_second_o),
    .gpr_flat_o(gpr_flat_o), .done_o(done_o), .invalid_o(invalid_o));

  cxt_periph u_periph (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .system_code_bus_i(system_code_bus_o), .system_command_strobe_n_i(system_command_strobe_n_o),
    .stop_req_o(stop_req), .idle_req_o(idle_req));

  // Memory content derived from the address; a changing pattern when not read
  function automatic logic [7:0] memf(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  assign dm_rdata_i = (dm_rd_o === 1'b1) ? memf(dm_addr_o) : cyc ^ 8'ha5;

  always @(negedge clk_sys_i) begin
    cyc <= cyc + 8'h01;
    if (stop_req === 1'b1) gstop++;
    if (idle_req === 1'b1) gidle++;
    if (done_o === 1'b1 || invalid_o === 1'b1) begin
      compares++;
      ex = expq.size() > 0 ? expq.pop_front() : 'x;
      if ({invalid_o, system_command_strobe_n_o, program_counter_o, status_o, index_pair_first_o,
           index_pair_second_o, gpr_flat_o, system_code_bus_o} !== ex) begin
        errors++;
        $display("wrong value at %0t: retired state differs", $time);
      end
    end
  end

  task automatic run_op(input cxt_pkg::cxt_op_t o, input logic [7:0] im);
    cxt_pkg::cxt_src_t s;
    cxt_pkg::cxt_idm_t m;
    cxt_pkg::cxt_spr_t sp;
    logic [1:0]        g, gs;
    logic              x, e, inv, rdy;
    logic [4:0]        f;
    logic [15:0]       base, sum, dif, adr;
    logic [7:0]        v, res;
    int                n;
    s = cxt_pkg::cxt_src_t'($urandom_range(3));
    m = cxt_pkg::cxt_idm_t'($urandom_range(3));
    sp = cxt_pkg::cxt_spr_t'($urandom_range(4));
    {g, gs, x, e, f} = 11'($urandom);
    inv = 1'b0;
    base = {index_high_byte, x ? il1 : il0};
    sum = base + {11'h000, f};
    dif = base - {11'h000, f};
    adr = m == cxt_pkg::IDM_POST_ADD ? base : m == cxt_pkg::IDM_ADD_KEEP ? sum : dif;
    if (s == cxt_pkg::SRC_DIR) adr = {e ? index_high_byte : 8'h00, im};
    if (o == cxt_pkg::OP_SWAP) begin
      inv = sp == cxt_pkg::SPR_SR0 || sp == cxt_pkg::SPR_SR1;
      v = sp == cxt_pkg::SPR_IDH ? index_high_byte : sp == cxt_pkg::SPR_INDEX_LOW_BYTE_FIRST ? il0 : il1;
      if (!inv && sp == cxt_pkg::SPR_IDH) index_high_byte = gpr[g];
      if (!inv && sp == cxt_pkg::SPR_INDEX_LOW_BYTE_FIRST) il0 = gpr[g];
      if (!inv && sp == cxt_pkg::SPR_IDL1) il1 = gpr[g];
      if (!inv) gpr[g] = v;
    end else if (o == cxt_pkg::OP_SYS) begin
      cd = im;
      nstop += int'(im == 8'h0a);
      nidle += int'(im == 8'h05);
    end else if (o != cxt_pkg::OP_NOP) begin
      v = s == cxt_pkg::SRC_IMM ? im : s == cxt_pkg::SRC_GPR ? gpr[gs] : memf(adr);
      res = o == cxt_pkg::OP_TM ? gpr[g] & im : gpr[g] ^ v;
      if (o == cxt_pkg::OP_XOR) gpr[g] = res;
      st[1] = res == 8'h00;
      st[3] = res[7];
      if (o == cxt_pkg::OP_XOR && s == cxt_pkg::SRC_IDM && m == cxt_pkg::IDM_POST_ADD) begin
        if (x) il1 = sum[7:0];
        else il0 = sum[7:0];
      end
      if (o == cxt_pkg::OP_XOR && s == cxt_pkg::SRC_IDM && m == cxt_pkg::IDM_PRE_SUB) begin
        if (x) il1 = dif[7:0];
        else il0 = dif[7:0];
      end
    end
    if (!inv) pc = pc + 20'h00001;
    expq.push_back({inv, o != cxt_pkg::OP_SYS, pc, st, {index_high_byte, il0}, {index_high_byte, il1},
                    {gpr[3], gpr[2], gpr[1], gpr[0]}, cd});
    instr_valid_i <= 1'b1;
    op_i <= o;
    src_i <= s;
    idm_i <= m;
    spr_sel_i <= sp;
    gpr_sel_i <= g;
    gpr_src_i <= gs;
    idx_sel_i <= x;
    offset_i <= f;
    imm_i <= im;
    eid_i <= e;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      rdy = (instr_ready_o === 1'b1);
      @(posedge clk_sys_i);
      n++;
    end while (!rdy && n < 20);
    if (!rdy) begin
      errors++;
      $display("wrong value at %0t: instruction never accepted", $time);
    end
  endtask

  task automatic complete_run;
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(40 * 6000);
    errors++;
    complete_run();
  end

  initial begin
    cxt_pkg::cxt_op_t ops [5];
    ops = '{cxt_pkg::OP_SWAP, cxt_pkg::OP_SYS, cxt_pkg::OP_TM, cxt_pkg::OP_XOR, cxt_pkg::OP_NOP};
    void'($urandom(83));
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    run_op(cxt_pkg::OP_SYS, 8'h0a);
    run_op(cxt_pkg::OP_SYS, 8'h05);
    run_op(cxt_pkg::OP_TM, 8'h00);
    for (int i = 0; i < 600; i++) begin
      run_op(ops[$urandom_range(4)], 8'($urandom));
      if ($urandom_range(3) == 0) begin
        instr_valid_i <= 1'b0;
        @(posedge clk_sys_i);
      end
    end
    instr_valid_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    compares++;
    if (expq.size() != 0 || nstop != gstop || nidle != gidle) begin
      errors++;
      $display("wrong value at %0t: missing retire or command decode", $time);
    end
    complete_run();
  end
endmodule
